/* File: fdp_defs.vh */
// constants for the flash and debug protection control block
`ifndef FDP_DEFS_VH
`define FDP_DEFS_VH
`define FDP_MODE_W      2
`define FDP_MODE_OPEN   2'h0
`define FDP_MODE_PROT   2'h1
`define FDP_MODE_KILL   2'h2
`define FDP_ROWS        32
`define FDP_ROW_W       5
`define FDP_OP_W        2
`define FDP_OP_READ     2'h0
`define FDP_OP_WRITE    2'h1
`define FDP_OP_ERASE    2'h2
`define FDP_OP_ALLERASE 2'h3
`define FDP_DBG_INIT    1'b1
`define FDP_SEC_INIT    1'b0
`define FDP_ERASED_INIT 1'b1
`endif

/* File: fdp_flag_cell.v */
// one protection flag kept across reset, set and clear by request
`timescale 1ns/1ps
module fdp_flag_cell (
  input  wire sys_clk,
  input  wire setReq,
  input  wire clrReq,
  input  wire resetVal,
  input  wire loadInit,
  output reg  flag_q
);
  always @(posedge sys_clk) begin
    if (loadInit) begin
      flag_q <= resetVal;
    end else if (setReq) begin
      flag_q <= 1'b1;
    end else if (clrReq) begin
      flag_q <= 1'b0;
    end
  end
endmodule // fdp_flag_cell

/* File: fdp_probe_model.sv */
// probe model on the gated debug and flash port
`timescale 1ns/1ps
module fdp_probe_model (
  input  wire logic       sys_clk,
  output logic            dbgReq = 1'h0,
  output logic            extReq = 1'h0,
  output logic      [1:0] extOp = 2'h0,
  output logic      [4:0] extRow = 5'h0
);
  task go;
    @(posedge sys_clk);
    #1;
  endtask
  task dbg;
    go;
    dbgReq <= 1'h1;
    go;
    dbgReq <= 1'h0;
  endtask
  // released lines show the inverse
  task ext(input logic [1:0] op, input logic [4:0] row);
    go;
    {extReq, extOp, extRow} <= {1'h1, op, row};
    go;
    {extReq, extOp, extRow} <= {1'h0, ~op, ~row};
  endtask
endmodule // fdp_probe_model

/* File: fdp_protect_ctrl.v */
// flash and debug protection mode controller
// Contract
// - leaves reset in open mode, debug usable
// - user may go open to protected
// - protected mode blocks debug port access
// - protected to open only after full erase
// - user may go open to kill
// - kill mode refuses every debug access
// - kill mode rejects external erase requests
// - kill mode is never left; here nvInit still reloads open mode
// - per-row write block and read block
// - internal system-call flash ops always allowed
// - debug on by default, firmware only disables
// - debug re-enable needs erase, unprotect, firmware
// - maximum security disables all external interfaces
`timescale 1ns/1ps
`include "fdp_defs.vh"
module fdp_protect_ctrl (
  input  wire                   sys_clk,
  input  wire                   rst_n,
  input  wire                   nvInit,
  input  wire                   modeWe,
  input  wire [`FDP_MODE_W-1:0] modeReq,
  input  wire                   fwDbgOff,
  input  wire                   fwDbgOn,
  input  wire                   secEnable,
  input  wire                   rowCfgWe,
  input  wire [`FDP_ROW_W-1:0]  rowCfgRow,
  input  wire                   rowCfgRd,
  input  wire                   rowCfgWr,
  input  wire                   dbgReq,
  input  wire                   extReq,
  input  wire [`FDP_OP_W-1:0]   extOp,
  input  wire [`FDP_ROW_W-1:0]  extRow,
  input  wire                   sysReq,
  input  wire [`FDP_OP_W-1:0]   sysOp,
  input  wire [`FDP_ROW_W-1:0]  sysRow,
  output reg  [`FDP_MODE_W-1:0] mode_q,
  output reg                    dbgEnable_q,
  output reg                    secLocked_q,
  output reg                    dbgGrant_q,
  output reg                    extGrant_q,
  output reg                    extReject_q,
  output reg                    sysGrant_q,
  output reg  [`FDP_OP_W-1:0]   flashOp_q,
  output reg  [`FDP_ROW_W-1:0]  flashRow_q,
  output reg                    flashGo_q,
  output reg                    flashErased_q
);
  ////////////////////////////////////////////////////////////////////////////
  // mode transitions
  localparam [`FDP_MODE_W-1:0] MODE_OPEN = `FDP_MODE_OPEN;
  localparam [`FDP_MODE_W-1:0] MODE_PROT = `FDP_MODE_PROT;
  localparam [`FDP_MODE_W-1:0] MODE_KILL = `FDP_MODE_KILL;
  reg  [`FDP_MODE_W-1:0] mode_d;
  wire                   fullErase;
  wire                   extOk;
  wire                   isOpen   = (mode_q == MODE_OPEN);
  wire                   isProt   = (mode_q == MODE_PROT);
  wire                   isKill   = (mode_q == MODE_KILL);
  wire                   wantOpen = modeWe && (modeReq == MODE_OPEN);
  wire                   wantProt = modeWe && (modeReq == MODE_PROT);
  wire                   wantKill = modeWe && (modeReq == MODE_KILL);

  // kill has no way out; protect reopens only on blank flash
  always @* begin
    mode_d = mode_q;
    case (mode_q)
      MODE_OPEN: begin
        if (wantProt) begin
          mode_d = MODE_PROT;
        end else if (wantKill) begin
          mode_d = MODE_KILL;
        end else begin
          mode_d = MODE_OPEN;
        end
      end
      MODE_PROT: begin
        if (wantOpen && flashErased_q) begin
          mode_d = MODE_OPEN;
        end else begin
          mode_d = MODE_PROT;
        end
      end
      MODE_KILL: begin
        mode_d = MODE_KILL;
      end
      default: begin
        mode_d = mode_q;
      end
    endcase
  end

  // nvInit marks power-on; rst_n alone keeps state (nonvolatile)
  always @(posedge sys_clk) begin
    if (nvInit) begin
      mode_q <= MODE_OPEN;
    end else begin
      mode_q <= mode_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // erase tracking: erased flag set by full erase, cleared by any write
  reg  flashErased_d;
  wire sysWrite     = sysReq && (sysOp == `FDP_OP_WRITE);
  wire extWrite     = extOk && (extOp == `FDP_OP_WRITE);
  wire sysFullErase = sysReq && (sysOp == `FDP_OP_ALLERASE);
  wire extFullErase = extOk && (extOp == `FDP_OP_ALLERASE);
  assign fullErase = sysFullErase || extFullErase;

  // a full erase outranks a write in the same cycle
  always @* begin
    if (fullErase) begin
      flashErased_d = 1'b1;
    end else if (sysWrite || extWrite) begin
      flashErased_d = 1'b0;
    end else begin
      flashErased_d = flashErased_q;
    end
  end

  always @(posedge sys_clk) begin
    if (nvInit) begin
      flashErased_q <= `FDP_ERASED_INIT;
    end else begin
      flashErased_q <= flashErased_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // debug enable and device security
  wire dbgFlag;
  wire secFlag;
  wire dbgOnOk = fwDbgOn && flashErased_q &&
                 (mode_q == `FDP_MODE_OPEN);
  fdp_flag_cell uDbg (
    .sys_clk  (sys_clk),
    .setReq   (dbgOnOk),
    .clrReq   (fwDbgOff),
    .resetVal (`FDP_DBG_INIT),
    .loadInit (nvInit),
    .flag_q   (dbgFlag)
  );
  fdp_flag_cell uSec (
    .sys_clk  (sys_clk),
    .setReq   (secEnable),
    .clrReq   (1'b0),
    .resetVal (`FDP_SEC_INIT),
    .loadInit (nvInit),
    .flag_q   (secFlag)
  );
  ////////////////////////////////////////////////////////////////////////////
  // row protection
  wire extRdBlk;
  wire extWrBlk;
  fdp_row_guard uRows (
    .sys_clk  (sys_clk),
    .loadInit (nvInit),
    .clrAll   (fullErase),
    .cfgWe    (rowCfgWe),
    .cfgRow   (rowCfgRow),
    .cfgRdBlk (rowCfgRd),
    .cfgWrBlk (rowCfgWr),
    .chkRow   (extRow),
    .rowRdBlk (extRdBlk),
    .rowWrBlk (extWrBlk)
  );
  ////////////////////////////////////////////////////////////////////////////
  // access gating
  wire portOpen = !secFlag && dbgFlag && isOpen;
  reg  rowOk;
  reg  killEr;
  reg  protEr;

  always @* begin
    rowOk  = 1'b1;
    killEr = 1'b0;
    protEr = 1'b0;
    case (extOp)
      `FDP_OP_READ: begin
        rowOk = !extRdBlk;
      end
      `FDP_OP_WRITE: begin
        rowOk = !extWrBlk;
      end
      `FDP_OP_ERASE: begin
        killEr = isKill;
      end
      `FDP_OP_ALLERASE: begin
        killEr = isKill;
        protEr = isProt && !secFlag;
      end
    endcase
  end
  assign extOk = extReq && !killEr && ((portOpen && rowOk) || protEr);
  ////////////////////////////////////////////////////////////////////////////
  // next output values
  reg                   dbgEnable_d;
  reg                   secLocked_d;
  reg                   dbgGrant_d;
  reg                   extGrant_d;
  reg                   extReject_d;
  reg                   sysGrant_d;
  reg                   flashGo_d;
  reg [`FDP_OP_W-1:0]   flashOp_d;
  reg [`FDP_ROW_W-1:0]  flashRow_d;

  always @* begin
    dbgEnable_d = portOpen;
    secLocked_d = secFlag;
    dbgGrant_d  = dbgReq && portOpen;
    extGrant_d  = extOk;
    extReject_d = extReq && !extOk;
    sysGrant_d  = sysReq;
    flashGo_d   = sysReq || extOk;
  end

  // system calls win the flash command when both arrive together
  always @* begin
    if (sysReq) begin
      flashOp_d  = sysOp;
      flashRow_d = sysRow;
    end else if (extOk) begin
      flashOp_d  = extOp;
      flashRow_d = extRow;
    end else begin
      flashOp_d  = flashOp_q;
      flashRow_d = flashRow_q;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // output registers, cleared by the system reset only
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      dbgEnable_q <= 1'b0;
    end else begin
      dbgEnable_q <= dbgEnable_d;
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      secLocked_q <= 1'b0;
    end else begin
      secLocked_q <= secLocked_d;
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      dbgGrant_q <= 1'b0;
    end else begin
      dbgGrant_q <= dbgGrant_d;
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      extGrant_q <= 1'b0;
    end else begin
      extGrant_q <= extGrant_d;
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      extReject_q <= 1'b0;
    end else begin
      extReject_q <= extReject_d;
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      sysGrant_q <= 1'b0;
    end else begin
      sysGrant_q <= sysGrant_d;
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      flashGo_q <= 1'b0;
    end else begin
      flashGo_q <= flashGo_d;
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      flashOp_q <= `FDP_OP_READ;
    end else begin
      flashOp_q <= flashOp_d;
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      flashRow_q <= {`FDP_ROW_W{1'b0}};
    end else begin
      flashRow_q <= flashRow_d;
    end
  end
endmodule // fdp_protect_ctrl

/* File: fdp_protect_props.sv */
// checker on the protection mode controller ports
`timescale 1ns/1ps
`include "fdp_defs.vh"
module fdp_protect_props (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       nvInit,
  input wire logic       modeWe,
  input wire logic [1:0] modeReq,
  input wire logic       dbgReq,
  input wire logic       extReq,
  input wire logic [1:0] extOp,
  input wire logic       sysReq,
  input wire logic [1:0] mode_q,
  input wire logic       flashErased_q,
  input wire logic       dbgGrant_q,
  input wire logic       extReject_q,
  input wire logic       sysGrant_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire inKill = mode_q == `FDP_MODE_KILL;
  wire inProt = mode_q == `FDP_MODE_PROT;
  wire chg = modeWe && !nvInit;
  a_kill_kept: assert property (inKill && !nvInit |=> inKill)
    else $error("kill left");
  a_kill_nodbg: assert property (inKill && dbgReq |=> !dbgGrant_q)
    else $error("kill dbg");
  a_prot_nodbg: assert property (inProt && dbgReq |=> !dbgGrant_q)
    else $error("prot dbg");
  a_kill_noerase: assert property (inKill && extReq && extOp[1]
    |=> extReject_q) else $error("kill erase");
  a_sys_served: assert property (sysReq |=> sysGrant_q)
    else $error("sys refused");
  a_prot_kill: assert property (inProt && chg
    && modeReq == `FDP_MODE_KILL |=> inProt) else $error("prot kill");
  a_open_prot: assert property (mode_q == `FDP_MODE_OPEN && chg
    && modeReq == `FDP_MODE_PROT |=> inProt) else $error("no prot");
  a_erase_first: assert property (inProt && chg && !flashErased_q
    && modeReq == `FDP_MODE_OPEN |=> inProt) else $error("early open");
endmodule // fdp_protect_props
bind fdp_protect_ctrl fdp_protect_props i_props (.*);

/* File: fdp_row_guard.v */
// per-row read and write protection bits with access check
`timescale 1ns/1ps
`include "fdp_defs.vh"
module fdp_row_guard (
  input  wire                   sys_clk,
  input  wire                   loadInit,
  input  wire                   clrAll,
  input  wire                   cfgWe,
  input  wire [`FDP_ROW_W-1:0]  cfgRow,
  input  wire                   cfgRdBlk,
  input  wire                   cfgWrBlk,
  input  wire [`FDP_ROW_W-1:0]  chkRow,
  output wire                   rowRdBlk,
  output wire                   rowWrBlk
);
  reg [`FDP_ROWS-1:0] rdBlk_q;
  reg [`FDP_ROWS-1:0] wrBlk_q;
  always @(posedge sys_clk) begin
    if (loadInit || clrAll) begin
      rdBlk_q <= {`FDP_ROWS{1'b0}};
      wrBlk_q <= {`FDP_ROWS{1'b0}};
    end else if (cfgWe) begin
      rdBlk_q[cfgRow] <= cfgRdBlk;
      wrBlk_q[cfgRow] <= cfgWrBlk;
    end
  end
  assign rowRdBlk = rdBlk_q[chkRow];
  assign rowWrBlk = wrBlk_q[chkRow];
endmodule // fdp_row_guard

/* File: tb.sv */
// bench for the protection mode controller
`timescale 1ns/1ps
`include "fdp_defs.vh"
module tb;
  logic sys_clk = 1'h0, rst_n = 1'h0, nvInit = 1'h1, modeWe = 1'h0;
  logic fwDbgOff = 1'h0, fwDbgOn = 1'h0, secEnable = 1'h0, sysReq = 1'h0;
  logic rowCfgWe = 1'h0, rowCfgRd = 1'h0, rowCfgWr = 1'h0;
  logic [1:0] modeReq = 2'h0, sysOp = 2'h0;
  logic [4:0] rowCfgRow = 5'h0, sysRow = 5'h0;
  wire [1:0] mode_q, extOp, flashOp_q;
  wire [4:0] extRow, flashRow_q;
  wire dbgReq, extReq, dbgEnable_q, secLocked_q, dbgGrant_q, extGrant_q;
  wire extReject_q, sysGrant_q, flashGo_q, flashErased_q;
  int num_errors = 0, check_count = 0;
  fdp_protect_ctrl i_dut (.*);
  fdp_probe_model i_probe (.*);
  always #12.5 sys_clk = ~sys_clk;
  task chk(input logic [7:0] got, exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task setMode(input logic [1:0] m, exp);
    i_probe.go;
    {modeWe, modeReq} <= {1'h1, m};
    i_probe.go;
    modeWe <= 1'h0;
    chk(mode_q, exp);
  endtask
  task t_rows;
    i_probe.dbg;
    chk({mode_q, dbgGrant_q}, 8'h1);
    {rowCfgWe, rowCfgRd, rowCfgWr, rowCfgRow} <= {3'h7, 5'h3};
    i_probe.go;
    {rowCfgWe, rowCfgRd, rowCfgWr} <= 3'h0;
    i_probe.ext(`FDP_OP_WRITE, 5'h3);
    chk(extReject_q, 8'h1);
    i_probe.ext(`FDP_OP_READ, 5'h3);
    chk({extGrant_q, extReject_q}, 8'h1);
    i_probe.ext(`FDP_OP_READ, 5'h4);
    chk({extGrant_q, extReject_q}, 8'h2);
    {sysReq, sysOp, sysRow} <= {1'h1, `FDP_OP_WRITE, 5'h3};
    i_probe.go;
    sysReq <= 1'h0;
    chk({sysGrant_q, flashRow_q}, 8'h23);
    $display("rows done");
  endtask
  task t_prot;
    setMode(`FDP_MODE_PROT, `FDP_MODE_PROT);
    i_probe.dbg;
    chk(dbgGrant_q, 8'h0);
    setMode(`FDP_MODE_OPEN, `FDP_MODE_PROT);
    i_probe.ext(`FDP_OP_ALLERASE, 5'h0);
    chk({extGrant_q, flashErased_q}, 8'h3);
    setMode(`FDP_MODE_OPEN, `FDP_MODE_OPEN);
    fwDbgOff <= 1'h1;
    i_probe.go;
    fwDbgOff <= 1'h0;
    i_probe.go;
    chk(dbgEnable_q, 8'h0);
    fwDbgOn <= 1'h1;
    i_probe.go;
    fwDbgOn <= 1'h0;
    i_probe.go;
    chk(dbgEnable_q, 8'h1);
    $display("prot done");
  endtask
  task t_kill;
    setMode(`FDP_MODE_PROT, `FDP_MODE_PROT);
    setMode(`FDP_MODE_KILL, `FDP_MODE_PROT);
    setMode(`FDP_MODE_OPEN, `FDP_MODE_OPEN);
    setMode(`FDP_MODE_KILL, `FDP_MODE_KILL);
    i_probe.dbg;
    chk(dbgGrant_q, 8'h0);
    i_probe.ext(`FDP_OP_ERASE, 5'h1);
    chk({extGrant_q, extReject_q}, 8'h1);
    setMode(`FDP_MODE_OPEN, `FDP_MODE_KILL);
    rst_n <= 1'h0;
    i_probe.go;
    {rst_n, secEnable} <= 2'h3;
    chk(mode_q, `FDP_MODE_KILL);
    i_probe.go;
    secEnable <= 1'h0;
    i_probe.go;
    chk(secLocked_q, 8'h1);
    $display("kill done");
  endtask
  task conclude;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (5) i_probe.go;
    {rst_n, nvInit} <= 2'h2;
    t_rows;
    t_prot;
    t_kill;
    conclude;
  end
  initial begin
    repeat (400) @(posedge sys_clk);
    num_errors++;
    conclude;
  end
endmodule // tb
